// >>> bench/ebsr_regs_sva.sv
`default_nettype none
module ebsr_regs_sva
(
  // Clock, reset, variant
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_six_input,
  // Register port
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  // Switch and bias controls
  input wire logic [14:0] o_first_source_sw,
  input wire logic [14:0] o_second_source_sw,
  input wire logic        o_bias_level_select,
  input wire logic        o_bias_gen_enable,
  input wire logic        o_bias_to_common_input,
  input wire logic [5:0]  o_bias_to_input,
  // System control fields
  input wire logic [2:0]  o_monitor_select,
  input wire logic [1:0]  o_calibration_sample_count,
  input wire logic        o_timeout_enable,
  input wire logic        o_checksum_enable,
  input wire logic        o_status_byte_enable
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Routing write seen at the port
  wire logic w7 = i_wr && i_addr == 8'h07;
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_read: assert property (i_rd && !(i_addr inside {[8'h07:8'h09]})
    |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_bias_fields: assert property (i_wr && i_addr == 8'h08 |=>
    {o_bias_level_select, o_bias_to_common_input, o_bias_to_input} == $past(i_wdata))
    else $error("bias fields wrong");
  a_bias_gen_or: assert property (o_bias_gen_enable ==
    $past(o_bias_to_common_input || |o_bias_to_input)) else $error("bias gen wrong");
  a_second_common: assert property (w7 && i_wdata[7:4] == 4'hc
    |=> ##1 o_second_source_sw == 15'h1000) else $error("second common wrong");
  a_first_low: assert property (w7 && i_wdata[3:0] < 4'h6
    |=> ##1 o_first_source_sw == 15'h1 << $past(i_wdata[3:0], 2))
    else $error("first input wrong");
  a_six_ref_pos: assert property (i_six_input && w7 && i_wdata[3:0] == 4'h6
    |=> ##1 o_first_source_sw == 15'h2000) else $error("reference switch wrong");
  a_first_off: assert property (w7 && i_wdata[3:0] > 4'hc
    |=> ##1 o_first_source_sw == 15'h0) else $error("first not off");
  a_sysctl_fields: assert property (i_wr && i_addr == 8'h09 |=>
    {o_monitor_select, o_calibration_sample_count, o_timeout_enable, o_checksum_enable,
     o_status_byte_enable} == $past(i_wdata)) else $error("system control fields wrong");
endmodule
bind ebsr_regs ebsr_regs_sva u_sva (.*);
`default_nettype wire

// >>> bench/tb_ebsr_regs.sv
`default_nettype none
module tb_ebsr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, six = 0, wr = 0, rd = 0;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rdata;
  logic [14:0] sw1, sw2;
  int          errors = 0, checked = 0;
  always #25 clk = ~clk;
  ebsr_regs dut (.i_sys_clk(clk), .i_rst(rst), .i_six_input(six), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_first_source_sw(sw1),
    .o_second_source_sw(sw2), .o_bias_level_select(), .o_bias_gen_enable(),
    .o_bias_to_common_input(), .o_bias_to_input(), .o_monitor_select(),
    .o_calibration_sample_count(), .o_timeout_enable(), .o_checksum_enable(),
    .o_status_byte_enable());
  // Compare and count
  task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle strobes, launched right after an edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp({7'h00, rdata}, {7'h00, e});
  endtask
  // Expected one-hot switch for a code and variant
  function automatic logic [14:0] sel(input logic [3:0] c, input logic s);
    if (c < 4'h6 || (!s && c < 4'hc))
      return 15'h1 << c;
    if (s && c inside {4'h6, 4'h7})
      return 15'h2000 << (c - 4'h6);
    return (c == 4'hc) ? 15'h1000 : 15'h0;
  endfunction
  task automatic conclude();
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h07, 8'hff);
    rd_reg(8'h08, 8'h00);
    rd_reg(8'h09, 8'h10);
    wr_reg(8'h08, 8'ha5);
    rd_reg(8'h08, 8'ha5);
    wr_reg(8'h08, 8'h80);
    wr_reg(8'h09, 8'hef);
    rd_reg(8'h09, 8'hef);
    wr_reg(8'h0a, 8'h55);
    rd_reg(8'h0a, 8'h00);
    rd_reg(8'h07, 8'hff);
    // Every code on both variants, complementary nibbles
    for (int k = 0; k < 32; k++)
    begin
      @(posedge clk);
      six <= k[4];
      wr_reg(8'h07, {k[3:0], ~k[3:0]});
      repeat (2) @(negedge clk);
      cmp(sw2, sel(k[3:0], k[4]));
      cmp(sw1, sel(~k[3:0], k[4]));
    end
    conclude();
  end
  // Hang guard, well beyond the roughly 160 cycles needed
  initial
  begin
    #100us;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire

// >>> common/ebsr_pkg.sv
// Summary of operation
// - Routing register at 07h, resets FFh
// - Upper nibble routes second source, decoded
// - Lower nibble routes first source, decoded
// - Six-input variant swaps 6/7 for references
// - Bias register at 08h, resets 00h
// - Bit 7 picks midpoint or twelfth level
// - Bias generator off unless any input connected
// - Bit 6 common, bits 5:0 inputs
// - Any combination of bias connects allowed
// - System control at 09h, resets 10h
`default_nettype none
package ebsr_pkg;
  // Register offsets
  localparam logic [7:0] EBSR_ADDR_ROUTING = 8'h07;
  localparam logic [7:0] EBSR_ADDR_BIAS    = 8'h08;
  localparam logic [7:0] EBSR_ADDR_SYSCTL  = 8'h09;
  // Reset values
  localparam logic [7:0] EBSR_RST_ROUTING  = 8'hff;
  localparam logic [7:0] EBSR_RST_BIAS     = 8'h00;
  localparam logic [7:0] EBSR_RST_SYSCTL   = 8'h10;
  // Field positions
  localparam int EBSR_SECOND_LSB  = 4;
  localparam int EBSR_LEVEL_BIT   = 7;
  localparam int EBSR_COMMON_BIT  = 6;
  localparam int EBSR_MON_LSB     = 5;
  localparam int EBSR_CAL_LSB     = 3;
  localparam int EBSR_TIMEOUT_BIT = 2;
  localparam int EBSR_CRC_BIT     = 1;
  localparam int EBSR_STAT_BIT    = 0;
  // Channel decode codes
  localparam logic [3:0] EBSR_CODE_LAST_INPUT = 4'hb;
  localparam logic [3:0] EBSR_CODE_LAST_SIX   = 4'h5;
  localparam logic [3:0] EBSR_CODE_REF_POS    = 4'h6;
  localparam logic [3:0] EBSR_CODE_REF_NEG    = 4'h7;
  localparam logic [3:0] EBSR_CODE_COMMON     = 4'hc;
  localparam int EBSR_NUM_INPUTS = 12;
  // Per-source one-hot switch vector: [11:0] inputs, 12 common, 13 ref+, 14 ref-
  localparam int EBSR_SW_W = 15;
endpackage
`default_nettype wire

// >>> core/ebsr_regs.sv
// The address-and-strobe port was decided locally.
`default_nettype none
module ebsr_regs
(
  // Clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  // Device variant: high for six-input part
  input  wire logic                      i_six_input,
  // Register port
  input  wire logic [7:0]                i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  // Excitation switch controls
  output logic [ebsr_pkg::EBSR_SW_W-1:0] o_first_source_sw,
  output logic [ebsr_pkg::EBSR_SW_W-1:0] o_second_source_sw,
  // Bias controls
  output logic                           o_bias_level_select,
  output logic                           o_bias_gen_enable,
  output logic                           o_bias_to_common_input,
  output logic      [5:0]                o_bias_to_input,
  // System control fields
  output logic      [2:0]                o_monitor_select,
  output logic      [1:0]                o_calibration_sample_count,
  output logic                           o_timeout_enable,
  output logic                           o_checksum_enable,
  output logic                           o_status_byte_enable
);
  import ebsr_pkg::*;

  // Two excitation sources share the routing register
  localparam int NUM_SOURCES = 2;
  // Width of one channel code field
  localparam int CODE_W      = EBSR_SECOND_LSB;

  // Whole block state in one record, so reset and next state cannot drift
  typedef struct packed {
    logic [7:0]           routing;
    logic [7:0]           bias;
    logic [7:0]           sysctl;
    logic [7:0]           rdata;
    logic [EBSR_SW_W-1:0] sw1;
    logic [EBSR_SW_W-1:0] sw2;
    logic                 bias_en;
  } ebsr_state_type;

  // Reset image of the record
  localparam ebsr_state_type EBSR_STATE_RST = '{
    // Registers at their power-on values
    routing: EBSR_RST_ROUTING,
    bias:    EBSR_RST_BIAS,
    sysctl:  EBSR_RST_SYSCTL,
    // Read data idle, every switch open, generator off
    rdata:   8'h00,
    sw1:     '0,
    sw2:     '0,
    bias_en: 1'b0
  };

  // Registered state and its next value
  ebsr_state_type                         state_q;
  ebsr_state_type                         state_d;

  // Address decode
  logic                                   hit_routing;
  logic                                   hit_bias;
  logic                                   hit_sysctl;

  // Per-register write enables
  logic                                   wr_routing;
  logic                                   wr_bias;
  logic                                   wr_sysctl;

  // Read path; latched for exactly one cycle, zero otherwise
  logic [7:0]                             rd_value;

  // Switch bank layout, per source:
  //   bits 11:0  analog inputs 0 to 11
  //   bit  12    common input
  //   bit  13    second reference, positive side
  //   bit  14    second reference, negative side
  //   all zero   source disconnected
  logic [NUM_SOURCES-1:0][EBSR_SW_W-1:0]  src_sw;

  // Bias byte field views
  logic                                   bias_level;
  logic                                   bias_common;
  logic [5:0]                             bias_inputs;

  // Bias connect bits, common input down to input 0
  logic [EBSR_COMMON_BIT:0]               bias_connect;
  logic                                   bias_any;

  // System control field views
  logic [2:0]                             mon_field;
  logic [1:0]                             cal_field;
  logic                                   timeout_field;
  logic                                   checksum_field;
  logic                                   status_field;

  // One compare per register; unmapped addresses hit nothing
  assign hit_routing = (i_addr == EBSR_ADDR_ROUTING);
  assign hit_bias    = (i_addr == EBSR_ADDR_BIAS);
  assign hit_sysctl  = (i_addr == EBSR_ADDR_SYSCTL);

  // Writes elsewhere are dropped without trace
  assign wr_routing  = i_wr && hit_routing;
  assign wr_bias     = i_wr && hit_bias;
  assign wr_sysctl   = i_wr && hit_sysctl;

  // Read selection; a read never changes any register
  always_comb
  begin
    rd_value = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        EBSR_ADDR_ROUTING:
        begin
          rd_value = state_q.routing;
        end
        EBSR_ADDR_BIAS:
        begin
          rd_value = state_q.bias;
        end
        EBSR_ADDR_SYSCTL:
        begin
          rd_value = state_q.sysctl;
        end
        default:
        begin
          rd_value = 8'h00;  // Unmapped reads give zero
        end
      endcase
    end
  end

  // One decoder per source: low nibble first, high nibble second;
  // the first source reuses the second's common and open codes
  for (genvar g = 0; g < NUM_SOURCES; g++)
  begin : g_source
    // Code field of this source
    logic [CODE_W-1:0]    code;
    // One-hot switch bank of this source
    logic [EBSR_SW_W-1:0] sw;

    // Field of this source inside the routing byte
    assign code = state_q.routing[g*CODE_W +: CODE_W];

    // Six-input part: 6 and 7 reach the second reference pair,
    // 8 to 11 have no pin there and leave the source open.
    // Strap is read live: a change re-decodes the held code next edge
    always_comb
    begin
      sw = '0;
      case (code)
        EBSR_CODE_REF_POS:
        begin
          if (i_six_input)
          begin
            sw[EBSR_NUM_INPUTS+1] = 1'b1;
          end
          else
          begin
            sw[code] = 1'b1;
          end
        end

        EBSR_CODE_REF_NEG:
        begin
          if (i_six_input)
          begin
            sw[EBSR_NUM_INPUTS+2] = 1'b1;
          end
          else
          begin
            sw[code] = 1'b1;
          end
        end

        // Only the twelve-input part has pins here
        4'h8, 4'h9, 4'ha, 4'hb:
        begin
          if (!i_six_input)
          begin
            sw[code] = 1'b1;
          end
        end

        // Common input, same for both sources
        EBSR_CODE_COMMON:
        begin
          sw[EBSR_NUM_INPUTS] = 1'b1;
        end

        // Open codes, also the state after reset
        4'hd, 4'he, 4'hf:
        begin
          sw = '0;
        end

        // Codes 0 to 5 are inputs on both variants
        default:
        begin
          sw[code] = 1'b1;
        end
      endcase
    end

    // Hand the bank to the shared next-state logic
    assign src_sw[g] = sw;
  end

  // Level bit sits above the connect bits and is not one of them
  assign bias_level  = state_q.bias[EBSR_LEVEL_BIT];
  assign bias_common = state_q.bias[EBSR_COMMON_BIT];
  assign bias_inputs = state_q.bias[EBSR_COMMON_BIT-1:0];

  // Any connect bit wakes the generator
  assign bias_connect = {bias_common, bias_inputs};
  assign bias_any     = |bias_connect;

  // Timing seen from the register port:
  //   edge 0  write strobe taken
  //   edge 1  register and field outputs show the new byte
  //   edge 2  switch banks and bias enable follow
  always_comb
  begin
    state_d = state_q;
    // Whole-byte writes; every bit is plain storage
    if (wr_routing)
    begin
      state_d.routing = i_wdata;
    end

    // Several bias connects may be set together
    if (wr_bias)
    begin
      state_d.bias = i_wdata;
    end

    if (wr_sysctl)
    begin
      state_d.sysctl = i_wdata;
    end

    // Read data stands one cycle, then falls back to zero
    state_d.rdata = rd_value;

    // Switches trail the stored code by a cycle, trading latency
    // for switch controls that never see a half-decoded code
    state_d.sw1 = src_sw[0];
    state_d.sw2 = src_sw[1];

    // Generator idles unless some connect bit is set
    state_d.bias_en = bias_any;
  end

  // State register; reset loads the whole image at once
  // Asynchronous reset opens every switch even with the clock stopped
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= EBSR_STATE_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // System control fields picked apart once
  assign mon_field      = state_q.sysctl[7:EBSR_MON_LSB];
  assign cal_field      = state_q.sysctl[EBSR_MON_LSB-1:EBSR_CAL_LSB];
  assign timeout_field  = state_q.sysctl[EBSR_TIMEOUT_BIT];
  assign checksum_field = state_q.sysctl[EBSR_CRC_BIT];
  assign status_field   = state_q.sysctl[EBSR_STAT_BIT];

  // Register port read data
  assign o_rdata                    = state_q.rdata;

  // Excitation switch banks
  assign o_first_source_sw          = state_q.sw1;
  assign o_second_source_sw         = state_q.sw2;

  // Bias level and generator
  assign o_bias_level_select        = bias_level;
  assign o_bias_gen_enable          = state_q.bias_en;

  // Bias connects, any mix allowed
  assign o_bias_to_common_input     = bias_common;
  assign o_bias_to_input            = bias_inputs;

  // System control fields
  assign o_monitor_select           = mon_field;
  assign o_calibration_sample_count = cal_field;
  assign o_timeout_enable           = timeout_field;
  assign o_checksum_enable          = checksum_field;
  assign o_status_byte_enable       = status_field;
endmodule
`default_nettype wire
